// ---- logic/timer_pair_pkg.sv ----
/*
 * Shared constants for the timer pair and external edge interrupt block:
 * register offsets, field positions, write masks, reset values, mode codes
 * and the CPU clock divider count.
 * Assumes an 8-bit register port with byte-wide registers.
 */
package timer_pair_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_TIMER_A_LOW_BYTE = 8'h8a;
    localparam logic [7:0] ADDR_TIMER_B_LOW_BYTE = 8'h8b;
    localparam logic [7:0] ADDR_TIMER_A_HIGH_BYTE = 8'h8c;
    localparam logic [7:0] ADDR_TIMER_B_HIGH_BYTE = 8'h8d;
    localparam logic [7:0] ADDR_EDGE_SELECT_CONTROL = 8'h8f;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_ZERO = 8'ha8;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in timer_control_flags.
    localparam int unsigned TCF_TIMER_B_OVERFLOW = 7;
    localparam int unsigned TCF_TIMER_B_RUN = 6;
    localparam int unsigned TCF_TIMER_A_OVERFLOW = 5;
    localparam int unsigned TCF_TIMER_A_RUN = 4;
    localparam int unsigned TCF_EXT_IRQ_REQUEST = 1;

    // Field positions in timer_mode.
    localparam int unsigned TMODE_TIMER_B_CLOCK = 6;
    localparam int unsigned TMODE_TIMER_B_MODE = 4;
    localparam int unsigned TMODE_TIMER_A_GATE_CONTROL = 3;
    localparam int unsigned TMODE_TIMER_A_CLOCK = 2;
    localparam int unsigned TMODE_TIMER_A_MODE = 0;

    // Field positions in interrupt_enable_zero.
    localparam int unsigned IEZ_GLOBAL_IRQ_ENABLE = 7;
    localparam int unsigned IEZ_TIMER_B_IRQ_ENABLE = 3;
    localparam int unsigned IEZ_TIMER_A_IRQ_ENABLE = 1;
    localparam int unsigned IEZ_EXT_IRQ_ENABLE = 0;

    ////////////////////////////////////////////////////////////////////////
    // Writable bits; every other bit reads as zero.
    localparam logic [7:0] TCF_WRITE_MASK = 8'hf2;
    localparam logic [7:0] TMODE_WRITE_MASK = 8'h7f;
    localparam logic [7:0] IEZ_WRITE_MASK = 8'h8b;
    localparam logic [7:0] EDGE_WRITE_MASK = 8'h03;

    // Reset values.
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] EDGE_SELECT_RESET = 2'h2;

    // Edge select codes; code 00 selects no edge.
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // The CPU timer clock is the core clock divided by twelve.
    localparam int unsigned CPU_CLOCK_DIVIDE = 12;
    localparam logic [3:0] CPU_DIVIDE_LAST = 4'(CPU_CLOCK_DIVIDE - 1);

    // Counting modes, in the order of their two-bit codes.
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } timer_mode_t;

endpackage : timer_pair_pkg

// ---- logic/timer_step.sv ----
/*
 * One counting step of a timer: from the present high and low bytes and a
 * count tick it gives the next bytes and an overflow pulse.
 * Assumes the caller gates the tick with run and gate conditions.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_step
    import timer_pair_pkg::*;
(
    input wire timer_mode_t mode,
    input wire logic tick,
    input wire logic [7:0] hi,
    input wire logic [7:0] lo,
    output logic [7:0] next_hi,
    output logic [7:0] next_lo,
    output logic overflow
);

    always_comb begin
        next_hi = hi;
        next_lo = lo;
        overflow = 1'b0;
        if (tick) begin
            case (mode)
                MODE_13BIT: begin
                    next_lo = {lo[7:5], lo[4:0] + 5'h01};
                    if (lo[4:0] == 5'h1f) begin
                        next_hi = hi + 8'h01;
                        overflow = (hi == 8'hff);
                    end
                end
                MODE_16BIT: begin
                    {next_hi, next_lo} = {hi, lo} + 16'h0001;
                    overflow = ({hi, lo} == 16'hffff);
                end
                MODE_8BIT_RELOAD: begin
                    if (lo == 8'hff) begin
                        next_lo = hi;
                        overflow = 1'b1;
                    end else begin
                        next_lo = lo + 8'h01;
                    end
                end
                MODE_SPLIT: begin
                    next_lo = lo + 8'h01;
                    overflow = (lo == 8'hff);
                end
                default: begin
                    next_lo = lo;
                end
            endcase
        end
    end

endmodule : timer_step

`default_nettype wire

// ---- logic/timer_pair.sv ----
/*
 * Two up-counting timers and one edge-triggered external interrupt with its
 * enable, flag and edge-select registers, reached over a plain register port.
 * Assumes a CPU interrupt controller on core_clk that takes the request
 * outputs and answers with one-cycle acknowledge pulses when it enters a
 * service routine; the pin and oscillator inputs are asynchronous.
 */
// Function
// - Edge select resets to falling; 01 rising, 10 falling, 11 both, 00 none.
// - Interrupt enable bit 0 gates the external request; resets to 0.
// - Interrupt enable bit 7 is a global enable for all requests; resets 0.
// - Control register bit 1 is the read/write external request flag.
// - With both enables set, a selected edge sets the external request flag.
// - The external flag clears by hardware as its service routine starts.
// - Timer A has four modes, timer B modes zero to two.
// - Each timer overflow request is gated by its own enable.
// - Clock is CPU or oscillator; gate control lets the pin pause counting.
// - Mode 0 counts 13 bits and flags the wrap from ff1f to 0000.
// - With enable clear firmware owns the flag; set, the controller clears it.
// - Mode 1 counts 16 bits and flags the wrap from ffff to 0000.
// - Mode 2 wrap flags overflow and reloads low byte from high byte.
// - Split mode low byte runs on timer A run bit and flag.
// - Split mode high byte counts at CPU clock over twelve, ungated.
// - In split mode the pin gate pauses only the low byte.
// - Split mode high byte runs on timer B run bit, sets its flag.
// - In split mode timer B counts but raises no overflow.
// - Mode field: 00 13-bit, 01 16-bit, 10 reload; 11 reserved for B.
`timescale 1ns/1ps
`default_nettype none

module timer_pair
    import timer_pair_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic ext_irq_pin,
    input wire logic osc_clk,
    input wire logic ack_ext,
    input wire logic ack_timer_a,
    input wire logic ack_timer_b,
    output logic [7:0] rdata,
    output logic irq_ext,
    output logic irq_timer_a,
    output logic irq_timer_b
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [7:0] control_flags;
        logic [7:0] timer_mode;
        logic [7:0] irq_enable;
        logic [1:0] edge_select;
        logic [7:0] timer_a_high_byte;
        logic [7:0] timer_a_low_byte;
        logic [7:0] timer_b_high_byte;
        logic [7:0] timer_b_low_byte;
        logic [3:0] cpu_divide;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic [7:0] rdata;
        logic irq_ext;
        logic irq_timer_a;
        logic irq_timer_b;
    } state_t;

    localparam state_t RESET_STATE = '{
        control_flags: BYTE_RESET,
        timer_mode: BYTE_RESET,
        irq_enable: BYTE_RESET,
        edge_select: EDGE_SELECT_RESET,
        timer_a_high_byte: BYTE_RESET,
        timer_a_low_byte: BYTE_RESET,
        timer_b_high_byte: BYTE_RESET,
        timer_b_low_byte: BYTE_RESET,
        cpu_divide: 4'h0,
        pin_s1: 1'b1,
        pin_s2: 1'b1,
        pin_s3: 1'b1,
        osc_s1: 1'b0,
        osc_s2: 1'b0,
        osc_s3: 1'b0,
        rdata: BYTE_RESET,
        irq_ext: 1'b0,
        irq_timer_a: 1'b0,
        irq_timer_b: 1'b0
    };

    state_t cur;
    state_t next_cur;

    ////////////////////////////////////////////////////////////////////////
    // Register read decode.
    function automatic logic [7:0] read_value(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_TIMER_CONTROL_FLAGS: v = s.control_flags & TCF_WRITE_MASK;
            ADDR_TIMER_MODE: v = s.timer_mode & TMODE_WRITE_MASK;
            ADDR_TIMER_A_LOW_BYTE: v = s.timer_a_low_byte;
            ADDR_TIMER_B_LOW_BYTE: v = s.timer_b_low_byte;
            ADDR_TIMER_A_HIGH_BYTE: v = s.timer_a_high_byte;
            ADDR_TIMER_B_HIGH_BYTE: v = s.timer_b_high_byte;
            ADDR_EDGE_SELECT_CONTROL: v = {6'h00, s.edge_select};
            ADDR_INTERRUPT_ENABLE_ZERO: v = s.irq_enable & IEZ_WRITE_MASK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    ////////////////////////////////////////////////////////////////////////
    // Tick and gate terms.
    timer_mode_t timer_a_mode;
    timer_mode_t timer_b_mode;
    logic split;
    logic cpu_tick;
    logic osc_tick;
    logic gate_open;
    logic timer_a_tick;
    logic timer_b_tick;
    logic split_high_tick;
    logic edge_hit;
    logic [1:0] step_tick;
    timer_mode_t step_mode [2];
    logic [7:0] step_hi_in [2];
    logic [7:0] step_lo_in [2];
    logic [7:0] step_hi [2];
    logic [7:0] step_lo [2];
    logic [1:0] step_ovf;

    // Mode fields.
    assign timer_a_mode = timer_mode_t'(cur.timer_mode[TMODE_TIMER_A_MODE +: 2]);
    assign timer_b_mode = timer_mode_t'(cur.timer_mode[TMODE_TIMER_B_MODE +: 2]);
    assign split = (timer_a_mode == MODE_SPLIT);
    assign cpu_tick = (cur.cpu_divide == CPU_DIVIDE_LAST);
    assign osc_tick = cur.osc_s2 & ~cur.osc_s3;

    // Gate: with gate control set, a low pin pauses timer A.
    assign gate_open = ~cur.timer_mode[TMODE_TIMER_A_GATE_CONTROL] | cur.pin_s2;

    // Timer A counts on its run bit and chosen clock.
    assign timer_a_tick = cur.control_flags[TCF_TIMER_A_RUN] & gate_open
        & (cur.timer_mode[TMODE_TIMER_A_CLOCK] ? osc_tick : cpu_tick);

    // Timer B: run bit outside split, free-running in split; code 11 holds it.
    assign timer_b_tick = (cur.timer_mode[TMODE_TIMER_B_CLOCK] ? osc_tick : cpu_tick)
        & (split | cur.control_flags[TCF_TIMER_B_RUN])
        & (timer_b_mode != MODE_SPLIT);

    // Split high byte: CPU clock over twelve, timer B run bit, no gate.
    assign split_high_tick = split & cur.control_flags[TCF_TIMER_B_RUN] & cpu_tick;

    // Edge detection on successive synchronised samples.
    always_comb begin
        case (cur.edge_select)
            EDGE_RISING: edge_hit = cur.pin_s2 & ~cur.pin_s3;
            EDGE_FALLING: edge_hit = ~cur.pin_s2 & cur.pin_s3;
            EDGE_BOTH: edge_hit = cur.pin_s2 ^ cur.pin_s3;
            default: edge_hit = 1'b0;
        endcase
    end

    assign step_tick = {timer_b_tick, timer_a_tick};
    assign step_mode[0] = timer_a_mode;
    assign step_mode[1] = timer_b_mode;
    assign step_hi_in[0] = cur.timer_a_high_byte;
    assign step_hi_in[1] = cur.timer_b_high_byte;
    assign step_lo_in[0] = cur.timer_a_low_byte;
    assign step_lo_in[1] = cur.timer_b_low_byte;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            timer_step u_step (
                .mode(step_mode[gi]),
                .tick(step_tick[gi]),
                .hi(step_hi_in[gi]),
                .lo(step_lo_in[gi]),
                .next_hi(step_hi[gi]),
                .next_lo(step_lo[gi]),
                .overflow(step_ovf[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic set_a;
        logic set_b;
        logic set_ext;
        logic split_high_ovf;
        set_a = 1'b0;
        set_b = 1'b0;
        set_ext = 1'b0;
        split_high_ovf = 1'b0;
        next_cur = cur;

        // Synchronisers.
        next_cur.pin_s1 = ext_irq_pin;
        next_cur.pin_s2 = cur.pin_s1;
        next_cur.pin_s3 = cur.pin_s2;
        next_cur.osc_s1 = osc_clk;
        next_cur.osc_s2 = cur.osc_s1;
        next_cur.osc_s3 = cur.osc_s2;

        next_cur.cpu_divide = cpu_tick ? 4'h0 : cur.cpu_divide + 4'h1;

        // Counters.
        next_cur.timer_a_high_byte = step_hi[0];
        next_cur.timer_a_low_byte = step_lo[0];
        next_cur.timer_b_high_byte = step_hi[1];
        next_cur.timer_b_low_byte = step_lo[1];
        if (split_high_tick) begin
            next_cur.timer_a_high_byte = cur.timer_a_high_byte + 8'h01;
            split_high_ovf = (cur.timer_a_high_byte == 8'hff);
        end

        // Overflow and edge events.
        set_a = step_ovf[0];
        set_b = split ? split_high_ovf : step_ovf[1];
        set_ext = edge_hit & cur.irq_enable[IEZ_EXT_IRQ_ENABLE]
            & cur.irq_enable[IEZ_GLOBAL_IRQ_ENABLE];

        // Set wins over acknowledge; acknowledge clears timer flags only when enabled, the external flag always.
        if (set_a) begin
            next_cur.control_flags[TCF_TIMER_A_OVERFLOW] = 1'b1;
        end else if (ack_timer_a & cur.irq_enable[IEZ_TIMER_A_IRQ_ENABLE]) begin
            next_cur.control_flags[TCF_TIMER_A_OVERFLOW] = 1'b0;
        end
        if (set_b) begin
            next_cur.control_flags[TCF_TIMER_B_OVERFLOW] = 1'b1;
        end else if (ack_timer_b & cur.irq_enable[IEZ_TIMER_B_IRQ_ENABLE]) begin
            next_cur.control_flags[TCF_TIMER_B_OVERFLOW] = 1'b0;
        end
        if (set_ext) begin
            next_cur.control_flags[TCF_EXT_IRQ_REQUEST] = 1'b1;
        end else if (ack_ext) begin
            next_cur.control_flags[TCF_EXT_IRQ_REQUEST] = 1'b0;
        end

        // Firmware writes override hardware updates.
        if (wr) begin
            case (addr)
                ADDR_TIMER_CONTROL_FLAGS: next_cur.control_flags = wdata & TCF_WRITE_MASK;
                ADDR_TIMER_MODE: next_cur.timer_mode = wdata & TMODE_WRITE_MASK;
                ADDR_TIMER_A_LOW_BYTE: next_cur.timer_a_low_byte = wdata;
                ADDR_TIMER_B_LOW_BYTE: next_cur.timer_b_low_byte = wdata;
                ADDR_TIMER_A_HIGH_BYTE: next_cur.timer_a_high_byte = wdata;
                ADDR_TIMER_B_HIGH_BYTE: next_cur.timer_b_high_byte = wdata;
                ADDR_EDGE_SELECT_CONTROL: next_cur.edge_select = wdata[1:0];
                ADDR_INTERRUPT_ENABLE_ZERO: next_cur.irq_enable = wdata & IEZ_WRITE_MASK;
                default: next_cur.rdata = next_cur.rdata;
            endcase
        end

        // Read data stand one cycle only.
        next_cur.rdata = rd ? read_value(cur, addr) : 8'h00;

        // Requests to the controller follow the flags and enables.
        next_cur.irq_ext = next_cur.irq_enable[IEZ_GLOBAL_IRQ_ENABLE]
            & next_cur.irq_enable[IEZ_EXT_IRQ_ENABLE]
            & next_cur.control_flags[TCF_EXT_IRQ_REQUEST];
        next_cur.irq_timer_a = next_cur.irq_enable[IEZ_GLOBAL_IRQ_ENABLE]
            & next_cur.irq_enable[IEZ_TIMER_A_IRQ_ENABLE]
            & next_cur.control_flags[TCF_TIMER_A_OVERFLOW];
        next_cur.irq_timer_b = next_cur.irq_enable[IEZ_GLOBAL_IRQ_ENABLE]
            & next_cur.irq_enable[IEZ_TIMER_B_IRQ_ENABLE]
            & next_cur.control_flags[TCF_TIMER_B_OVERFLOW];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;
    assign irq_ext = cur.irq_ext;
    assign irq_timer_a = cur.irq_timer_a;
    assign irq_timer_b = cur.irq_timer_b;

endmodule : timer_pair

`default_nettype wire

// ---- test/timer_pair_checker.sv ----
/*
 * Port checker for timer_pair, bound to the design.
 * Assumes writes to the enable and edge-select registers only come over the port.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_pair_checker
    import timer_pair_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic ext_irq_pin,
    input wire logic ack_ext,
    input wire logic [7:0] rdata,
    input wire logic irq_ext,
    input wire logic irq_timer_a,
    input wire logic irq_timer_b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    logic [7:0] en_q;
    logic [1:0] edge_q;

    ////////////////////////////////////////////////////////////////////////
    // Shadows of the enable and edge-select registers.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 8'h00;
            edge_q <= EDGE_SELECT_RESET;
        end else if (wr && addr == ADDR_INTERRUPT_ENABLE_ZERO) begin
            en_q <= wdata & IEZ_WRITE_MASK;
        end else if (wr && addr == ADDR_EDGE_SELECT_CONTROL) begin
            edge_q <= wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence fall_armed;
        $fell(ext_irq_pin) && edge_q[1] && en_q[7] && en_q[0];
    endsequence
    sequence ext_raised;
        ##[1:4] irq_ext;
    endsequence

    chk_fall_raises: assert property (fall_armed |-> ext_raised)
        else $error("external request missed a selected falling edge");
    chk_ext_gated: assert property (!(en_q[7] && en_q[0]) |-> !irq_ext)
        else $error("external request output high while disabled");
    chk_a_gated: assert property (!(en_q[7] && en_q[1]) |-> !irq_timer_a)
        else $error("timer a request output high while disabled");
    chk_b_gated: assert property (!(en_q[7] && en_q[3]) |-> !irq_timer_b)
        else $error("timer b request output high while disabled");
    chk_ack_clears: assert property (ack_ext |=> !irq_ext)
        else $error("external request survived its acknowledge");
    chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_edge_read: assert property (rd && addr == ADDR_EDGE_SELECT_CONTROL
        |=> rdata == {6'h00, $past(edge_q)})
        else $error("edge select read back wrong");
    chk_enable_read: assert property (rd && addr == ADDR_INTERRUPT_ENABLE_ZERO
        |=> rdata == $past(en_q))
        else $error("enable register read back wrong");

endmodule : timer_pair_checker

bind timer_pair timer_pair_checker timer_pair_checker_inst (.core_clk, .arst_n, .addr, .wdata,
    .wr, .rd, .ext_irq_pin, .ack_ext, .rdata, .irq_ext, .irq_timer_a, .irq_timer_b);

`default_nettype wire

// ---- test/irq_partner.sv ----
/*
 * Model of the interrupt pin source and the CPU interrupt controller.
 * Assumes the bench sets the pin level, the service switch and the delay.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_partner (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic pin_level,
    input wire logic service_on,
    input wire logic [3:0] ack_delay,
    input wire logic irq_ext,
    input wire logic irq_timer_a,
    input wire logic irq_timer_b,
    output wire logic ext_irq_pin,
    output logic ack_ext,
    output logic ack_timer_a,
    output logic ack_timer_b
);
    logic [3:0] wait_count;

    // The pin follows pin_level 3 ns later, so it moves just after a block clock edge.
    assign #3 ext_irq_pin = pin_level;

    // Service entry acknowledges the highest pending request after a delay.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_count <= 4'h0;
            ack_ext <= 1'b0;
            ack_timer_a <= 1'b0;
            ack_timer_b <= 1'b0;
        end else begin
            ack_ext <= 1'b0;
            ack_timer_a <= 1'b0;
            ack_timer_b <= 1'b0;
            if (!service_on || !(irq_ext || irq_timer_a || irq_timer_b)) begin
                wait_count <= 4'h0;
            end else if (wait_count < ack_delay) begin
                wait_count <= wait_count + 4'h1;
            end else begin
                wait_count <= 4'h0;
                ack_ext <= irq_ext;
                ack_timer_a <= !irq_ext && irq_timer_a;
                ack_timer_b <= !irq_ext && !irq_timer_a && irq_timer_b;
            end
        end
    end

endmodule : irq_partner

`default_nettype wire

// ---- test/timer_pair_tb.sv ----
/*
 * Self-checking bench for timer_pair with the controller model beside it.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module timer_pair_tb;
    import timer_pair_pkg::*;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic osc_clk = 1'b0;
    logic pin_level = 1'b1;
    logic service_on = 1'b0;
    logic [3:0] ack_delay = 4'h3;
    logic [7:0] rdata;
    logic irq_ext;
    logic irq_timer_a;
    logic irq_timer_b;
    wire ext_irq_pin;
    logic ack_ext;
    logic ack_timer_a;
    logic ack_timer_b;
    logic [7:0] seen;
    int fails = 0;
    int check_count = 0;

    always #12.5 core_clk = ~core_clk;
    always #60 osc_clk = ~osc_clk;

    timer_pair timer_pair_inst (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .ext_irq_pin(ext_irq_pin), .osc_clk(osc_clk),
        .ack_ext(ack_ext), .ack_timer_a(ack_timer_a), .ack_timer_b(ack_timer_b),
        .rdata(rdata), .irq_ext(irq_ext), .irq_timer_a(irq_timer_a), .irq_timer_b(irq_timer_b));
    irq_partner irq_partner_inst (.core_clk(core_clk), .arst_n(arst_n),
        .pin_level(pin_level), .service_on(service_on), .ack_delay(ack_delay),
        .irq_ext(irq_ext), .irq_timer_a(irq_timer_a), .irq_timer_b(irq_timer_b),
        .ext_irq_pin(ext_irq_pin), .ack_ext(ack_ext), .ack_timer_a(ack_timer_a),
        .ack_timer_b(ack_timer_b));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        seen = rdata;
    endtask : read_reg

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
        read_reg(a);
        check(name, seen, exp);
    endtask : expect_reg

    task automatic wait_flag(input int bit_pos);
        for (int i = 0; i < 60; i++) begin
            read_reg(ADDR_TIMER_CONTROL_FLAGS);
            if (seen[bit_pos] === 1'b1) return;
        end
        check("flag wait", 8'h00, 8'h01);
        end_of_test();
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    initial begin
        idle(6);
        arst_n <= 1'b1;
        expect_reg("control", ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        expect_reg("edge", ADDR_EDGE_SELECT_CONTROL, 8'h02);
        expect_reg("enable", ADDR_INTERRUPT_ENABLE_ZERO, 8'h00);
        write_reg(ADDR_INTERRUPT_ENABLE_ZERO, 8'hff);
        expect_reg("enable", ADDR_INTERRUPT_ENABLE_ZERO, 8'h8b);
        write_reg(8'h8e, 8'h55);
        expect_reg("unmapped", 8'h8e, 8'h00);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h02);
        expect_reg("ext flag", ADDR_TIMER_CONTROL_FLAGS, 8'h02);
        check("irq ext", {7'h00, irq_ext}, 8'h01);
        service_on <= 1'b1;
        idle(10);
        expect_reg("acked", ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        service_on <= 1'b0;
        for (int code = 0; code < 4; code++) begin
            write_reg(ADDR_EDGE_SELECT_CONTROL, 8'(code));
            pin_level <= 1'b0;
            idle(6);
            expect_reg("fall", ADDR_TIMER_CONTROL_FLAGS, {6'h00, code[1], 1'b0});
            write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
            pin_level <= 1'b1;
            idle(6);
            expect_reg("rise", ADDR_TIMER_CONTROL_FLAGS, {6'h00, code[0], 1'b0});
            write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        end
        write_reg(ADDR_INTERRUPT_ENABLE_ZERO, 8'h80);
        pin_level <= 1'b0;
        idle(6);
        expect_reg("ext off", ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        write_reg(ADDR_INTERRUPT_ENABLE_ZERO, 8'h01);
        pin_level <= 1'b1;
        idle(6);
        expect_reg("global off", ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        // Sixteen-bit wrap with the overflow request serviced.
        write_reg(ADDR_INTERRUPT_ENABLE_ZERO, 8'h82);
        write_reg(ADDR_TIMER_MODE, 8'h01);
        write_reg(ADDR_TIMER_A_HIGH_BYTE, 8'hff);
        write_reg(ADDR_TIMER_A_LOW_BYTE, 8'hfe);
        idle(30);
        expect_reg("stopped", ADDR_TIMER_A_LOW_BYTE, 8'hfe);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        wait_flag(TCF_TIMER_A_OVERFLOW);
        expect_reg("wrap 16", ADDR_TIMER_A_HIGH_BYTE, 8'h00);
        check("irq a", {7'h00, irq_timer_a}, 8'h01);
        service_on <= 1'b1;
        idle(10);
        expect_reg("a acked", ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        service_on <= 1'b0;
        // Thirteen-bit wrap, then eight-bit reload.
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        write_reg(ADDR_TIMER_MODE, 8'h00);
        write_reg(ADDR_TIMER_A_LOW_BYTE, 8'h1e);
        write_reg(ADDR_TIMER_A_HIGH_BYTE, 8'hff);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        wait_flag(TCF_TIMER_A_OVERFLOW);
        expect_reg("wrap 13", ADDR_TIMER_A_HIGH_BYTE, 8'h00);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        write_reg(ADDR_TIMER_MODE, 8'h02);
        write_reg(ADDR_TIMER_A_HIGH_BYTE, 8'h80);
        write_reg(ADDR_TIMER_A_LOW_BYTE, 8'hfe);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        wait_flag(TCF_TIMER_A_OVERFLOW);
        expect_reg("reload", ADDR_TIMER_A_LOW_BYTE, 8'h80);
        // Oscillator clock held by the gate while the pin is low.
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        write_reg(ADDR_TIMER_MODE, 8'h0d);
        write_reg(ADDR_TIMER_A_HIGH_BYTE, 8'hff);
        write_reg(ADDR_TIMER_A_LOW_BYTE, 8'hff);
        pin_level <= 1'b0;
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        idle(40);
        expect_reg("gated", ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        pin_level <= 1'b1;
        wait_flag(TCF_TIMER_A_OVERFLOW);
        // Split mode: low byte on run a, high byte on run b, timer b flagless.
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        write_reg(ADDR_INTERRUPT_ENABLE_ZERO, 8'h8a);
        write_reg(ADDR_TIMER_MODE, 8'h1b);
        write_reg(ADDR_TIMER_A_HIGH_BYTE, 8'hff);
        write_reg(ADDR_TIMER_A_LOW_BYTE, 8'hff);
        write_reg(ADDR_TIMER_B_HIGH_BYTE, 8'hff);
        write_reg(ADDR_TIMER_B_LOW_BYTE, 8'hff);
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h10);
        wait_flag(TCF_TIMER_A_OVERFLOW);
        idle(14);
        expect_reg("split", ADDR_TIMER_CONTROL_FLAGS, 8'h30);
        expect_reg("high held", ADDR_TIMER_A_HIGH_BYTE, 8'hff);
        pin_level <= 1'b0;
        write_reg(ADDR_TIMER_CONTROL_FLAGS, 8'h50);
        wait_flag(TCF_TIMER_B_OVERFLOW);
        expect_reg("high wrap", ADDR_TIMER_A_HIGH_BYTE, 8'h00);
        check("irq b", {7'h00, irq_timer_b}, 8'h01);
        // A second reset in mid-run.
        arst_n <= 1'b0;
        idle(2);
        arst_n <= 1'b1;
        expect_reg("control", ADDR_TIMER_CONTROL_FLAGS, 8'h00);
        expect_reg("edge", ADDR_EDGE_SELECT_CONTROL, 8'h02);
        end_of_test();
    end

endmodule : timer_pair_tb

`default_nettype wire
